// file: slp_pkg.sv
// Shared constants, types and decode helpers of the sleep controller pair
package slp_pkg;

  // ********************************
  // Power control register layout
  // ********************************
  localparam int PCR_W = 8;
  localparam int PCR_MODE2_BIT = 7;
  localparam int PCR_SE_BIT = 6;
  localparam int PCR_MODE1_BIT = 5;
  localparam int PCR_MODE0_BIT = 4;
  localparam int PCR_SENSE_LSB = 0;
  localparam int PCR_SENSE_W = 4;
  localparam logic [7:0] PCR_RESET = 8'h00;

  typedef enum logic [2:0] {
    MODE_IDLE  = 3'b000,
    MODE_NOISE = 3'b001,
    MODE_PDOWN = 3'b010,
    MODE_PSAVE = 3'b011,
    MODE_RSV4  = 3'b100,
    MODE_RSV5  = 3'b101,
    MODE_STBY  = 3'b110,
    MODE_XSTBY = 3'b111
  } slp_mode_t;

  // ********************************
  // Wake sources and clock domains
  // ********************************
  // Source bits: 0 conversion done, 1 level irq line zero/one, 2 line two,
  // 3 two-wire match, 4 third timer, 5 store ready, 6 edge irq, 7 other I/O
  localparam int W_NUM = 8;
  localparam logic [7:0] WMASK_NOISE = 8'h3F;
  localparam logic [7:0] WMASK_PDOWN = 8'h0E;
  localparam logic [7:0] WMASK_T2 = 8'h10;

  localparam int CK_NUM = 7;
  localparam int CK_CORE = 6;
  localparam int CK_FLASH = 5;
  localparam int CK_IO = 4;
  localparam int CK_ADC = 3;
  localparam int CK_ASY = 2;
  localparam int CK_OSC = 1;
  localparam int CK_TOSC = 0;
  localparam logic [6:0] CLK_ALL_ON = 7'h7F;

  // ********************************
  // Timing in clock cycles
  // ********************************
  localparam int DLY_W = 16;
  localparam logic [15:0] HALT_CYC = 16'h0004;
  localparam logic [15:0] STBY_WAKE_CYC = 16'h0006;
  localparam logic [1:0] ISR_CYC = 2'h2;

  // ********************************
  // Controller register map
  // ********************************
  localparam int HA_W = 3;
  localparam logic [2:0] HREG_PCR = 3'h0;
  localparam logic [2:0] HREG_CMD = 3'h1;
  localparam logic [2:0] HREG_STAT = 3'h2;
  localparam logic [2:0] HREG_PC = 3'h3;
  localparam int CMD_GO_BIT = 0;
  localparam int STAT_ASLEEP_BIT = 0;
  localparam int STAT_IRQ_BIT = 1;
  localparam int STAT_RST_BIT = 2;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_START = 2'b10,
    ST_HALT  = 2'b11
  } slp_dst_t;

  typedef enum logic [2:0] {
    C_IDLE   = 3'b000,
    C_SET_SE = 3'b001,
    C_SLEEP  = 3'b010,
    C_CHECK  = 3'b011,
    C_WAIT   = 3'b100,
    C_ISR    = 3'b101,
    C_CLR_SE = 3'b110
  } slp_cst_t;

  function automatic slp_mode_t slp_mode_of(input logic [7:0] pcr);
    return slp_mode_t'({pcr[PCR_MODE2_BIT], pcr[PCR_MODE1_BIT], pcr[PCR_MODE0_BIT]});
  endfunction

endpackage

// file: slp_if.sv
// Link between the processor side and the sleep controller
`timescale 1ns/1ps
interface slp_if;
  logic pcr_wr;
  logic [7:0] pcr_wdata;
  logic sleep_exec;
  logic [7:0] pcr_rdata;
  logic halted;
  logic wake_irq;
  logic wake_rst;

  modport dev (
    input pcr_wr, pcr_wdata, sleep_exec,
    output pcr_rdata, halted, wake_irq, wake_rst
  );
  modport cpu (
    output pcr_wr, pcr_wdata, sleep_exec,
    input pcr_rdata, halted, wake_irq, wake_rst
  );
endinterface

// file: slp_ctrl.sv
// Sleep-mode controller: power control register, clock gating, wake timing
//
// Summary of operation
// (RULE1) Sleep only with enable bit and instruction
// (RULE2) Three-bit field picks one of six modes
// (RULE3) Interrupt wake: start-up, four halt cycles, resume
// (RULE4) Wake keeps register file and memory intact
// (RULE5) Reset during sleep restarts at reset vector
// (RULE6) Control register bit layout, all zero at reset
// (RULE7) Software sets enable before, clears after sleep
// (RULE8) Idle stops only core and store clocks; the timer oscillator also stops unless the third timer is asynchronous
// (RULE9) Idle wakes on external and internal interrupts
// (RULE10) Idle or noise mode starts conversion
// (RULE11) Noise mode also stops peripheral clock
// (RULE12) Noise mode wake sources are limited
// (RULE13) Power-down stops oscillator and generated clocks
// (RULE14) Power-down wakes on resets, match, line irqs
// (RULE15) Level wake must be held long enough
// (RULE16) Power-down wake waits clock restart delay
// (RULE17) Power-save keeps asynchronous third timer running
// (RULE18) Synchronous third timer undefined after power-save
// (RULE19) Standby keeps oscillator, wakes in six cycles
// (RULE20) Extended standby keeps oscillator, six cycle wake
// (RULE21) Software may power comparator off in idle
// (RULE22) Reserved or unsupported codes do not sleep
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module slp_ctrl
  import slp_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Processor link
  slp_if.dev lnk,
  // Wake requests, already qualified by their enables
  input wire logic [W_NUM-1:0] i_wake_src,
  input wire logic i_reset_req,
  // Configuration
  input wire logic i_t2_async,
  input wire logic i_xtal_sel,
  input wire logic i_adc_en,
  input wire logic [DLY_W-1:0] i_startup_ck,
  // Clock gates and status
  output logic o_core_clk_en,
  output logic o_flash_clk_en,
  output logic o_io_clk_en,
  output logic o_adc_clk_en,
  output logic o_asy_clk_en,
  output logic o_osc_en,
  output logic o_tosc_en,
  output logic o_adc_start,
  output logic [PCR_SENSE_W-1:0] o_irq_sense,
  output logic o_t2_undef,
  output logic o_asleep,
  output logic [2:0] o_sleep_mode
);

  // ********************************
  // State
  // ********************************
  typedef struct packed {
    slp_dst_t st;
    logic [7:0] pcr;
    slp_mode_t mode;
    logic [DLY_W-1:0] cnt;
    logic by_rst;
    logic [CK_NUM-1:0] clk_en;
    logic adc_start;
    logic halted;
    logic wake_irq;
    logic wake_rst;
    logic t2_undef;
  } slp_dev_t;

  localparam slp_dev_t DEV_RST = '{
    st: ST_RUN,
    pcr: PCR_RESET,
    mode: MODE_IDLE,
    clk_en: CLK_ALL_ON,
    default: '0
  };

  slp_dev_t q;
  slp_dev_t d;
  slp_mode_t sel_mode;

  // ********************************
  // Mode decode
  // ********************************
  // Standby codes need a crystal; other unlisted codes never sleep
  function automatic logic mode_legal(input slp_mode_t m, input logic xtal);
    case (m)
      MODE_IDLE, MODE_NOISE, MODE_PDOWN, MODE_PSAVE: return 1'b1;
      MODE_STBY, MODE_XSTBY: return xtal; // RULE19 RULE20 RULE22
      default: return 1'b0; // RULE22
    endcase
  endfunction

  // Clocks kept alive per mode, order core,store,io,conv,asy,osc,tosc
  function automatic logic [CK_NUM-1:0] clk_set(input slp_mode_t m, input logic asy);
    case (m)
      MODE_IDLE: return {5'b00111, 1'b1, asy}; // RULE8
      MODE_NOISE: return {5'b00011, 1'b1, asy}; // RULE11
      MODE_PDOWN: return 7'h00; // RULE13
      MODE_PSAVE: return {4'b0000, asy, 1'b0, asy}; // RULE17
      MODE_STBY: return 7'h02; // RULE19
      MODE_XSTBY: return {4'b0000, asy, 1'b1, asy}; // RULE20
      default: return CLK_ALL_ON;
    endcase
  endfunction

  function automatic logic wake_ok(input slp_mode_t m, input logic [W_NUM-1:0] s,
                                   input logic asy);
    logic [W_NUM-1:0] msk;
    msk = '0;
    case (m)
      MODE_IDLE: msk = '1; // RULE9
      MODE_NOISE: msk = WMASK_NOISE; // RULE12
      MODE_PDOWN, MODE_STBY: msk = WMASK_PDOWN; // RULE14
      MODE_PSAVE, MODE_XSTBY: msk = WMASK_PDOWN | (asy ? WMASK_T2 : 8'h00); // RULE17
      default: msk = '0;
    endcase
    return |(s & msk);
  endfunction

  // Oscillator restart time; idle and noise modes never stop it
  function automatic logic [DLY_W-1:0] wake_dly(input slp_mode_t m,
                                                input logic [DLY_W-1:0] su);
    case (m)
      MODE_PDOWN, MODE_PSAVE: return su; // RULE16
      MODE_STBY, MODE_XSTBY: return STBY_WAKE_CYC; // RULE19 RULE20
      default: return '0;
    endcase
  endfunction

  assign sel_mode = slp_mode_of(q.pcr); // RULE2

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    logic [DLY_W-1:0] dly;
    dly = '0;
    d = q;
    d.adc_start = 1'b0;
    d.wake_irq = 1'b0;
    d.wake_rst = 1'b0;
    case (q.st)
      ST_RUN: begin
        if (i_reset_req) begin
          d.pcr = PCR_RESET;
          d.wake_rst = 1'b1;
        end else if (lnk.pcr_wr) begin
          d.pcr = lnk.pcr_wdata; // RULE6
        end else if (lnk.sleep_exec && q.pcr[PCR_SE_BIT]
                     && mode_legal(sel_mode, i_xtal_sel)) begin // RULE1 RULE22
          d.st = ST_SLEEP;
          d.mode = sel_mode;
          d.halted = 1'b1;
          d.t2_undef = 1'b0;
          d.clk_en = clk_set(sel_mode, i_t2_async);
          d.adc_start = i_adc_en
                        && (sel_mode == MODE_IDLE || sel_mode == MODE_NOISE); // RULE10
        end
      end
      ST_SLEEP: begin
        if (i_reset_req || wake_ok(q.mode, i_wake_src, i_t2_async)) begin
          d.by_rst = i_reset_req; // RULE5
          d.t2_undef = (q.mode == MODE_PSAVE) && !i_t2_async; // RULE18
          d.clk_en[CK_OSC] = 1'b1;
          dly = wake_dly(q.mode, i_startup_ck);
          if (dly == '0) begin
            d.clk_en = CLK_ALL_ON;
            d.st = ST_HALT;
            d.cnt = HALT_CYC - 16'h0001;
          end else begin
            d.st = ST_START;
            d.cnt = dly - 16'h0001; // RULE16
          end
          // Reset wake needs no halt: the core restarts from scratch
          if (i_reset_req && dly == '0) begin
            d.st = ST_RUN;
            d.halted = 1'b0;
            d.pcr = PCR_RESET;
            d.wake_rst = 1'b1; // RULE5
          end
        end
      end
      ST_START: begin
        if (q.cnt == '0) begin
          d.clk_en = CLK_ALL_ON;
          if (q.by_rst) begin
            d.st = ST_RUN;
            d.halted = 1'b0;
            d.pcr = PCR_RESET;
            d.wake_rst = 1'b1; // RULE5
          end else begin
            d.st = ST_HALT;
            d.cnt = HALT_CYC - 16'h0001; // RULE3
          end
        end else begin
          d.cnt = q.cnt - 16'h0001;
        end
      end
      ST_HALT: begin
        if (q.cnt == '0) begin
          // Register contents survive; only the halt is lifted
          d.st = ST_RUN;
          d.halted = 1'b0;
          d.wake_irq = 1'b1; // RULE3 RULE4
        end else begin
          d.cnt = q.cnt - 16'h0001; // RULE3
        end
      end
      default: d = DEV_RST;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= DEV_RST;
    end else begin
      q <= d;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  assign lnk.pcr_rdata = q.pcr;
  assign lnk.halted = q.halted;
  assign lnk.wake_irq = q.wake_irq;
  assign lnk.wake_rst = q.wake_rst;
  assign o_core_clk_en = q.clk_en[CK_CORE];
  assign o_flash_clk_en = q.clk_en[CK_FLASH];
  assign o_io_clk_en = q.clk_en[CK_IO];
  assign o_adc_clk_en = q.clk_en[CK_ADC];
  assign o_asy_clk_en = q.clk_en[CK_ASY];
  assign o_osc_en = q.clk_en[CK_OSC];
  assign o_tosc_en = q.clk_en[CK_TOSC];
  assign o_adc_start = q.adc_start;
  assign o_irq_sense = q.pcr[PCR_SENSE_LSB +: PCR_SENSE_W]; // RULE6
  assign o_t2_undef = q.t2_undef;
  assign o_asleep = q.halted;
  assign o_sleep_mode = q.mode;

endmodule // slp_ctrl

// file: slp_cpu.sv
// Processor-side sleep sequencer with a small software register port
`timescale 1ns/1ps
module slp_cpu
  import slp_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Link to the sleep controller
  slp_if.cpu lnk,
  // Software register port
  input wire logic [HA_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Status
  output logic o_busy,
  output logic o_isr_run,
  output logic [7:0] o_pc
);

  // ********************************
  // State
  // ********************************
  typedef struct packed {
    slp_cst_t st;
    logic [7:0] rdata;
    logic pcr_wr;
    logic [7:0] pcr_wdata;
    logic sleep_exec;
    logic [1:0] cnt;
    logic woke_irq;
    logic woke_rst;
    logic isr;
    logic [7:0] pc;
    logic busy;
  } slp_cpu_t;

  localparam slp_cpu_t CPU_RST = '{st: C_IDLE, default: '0};

  slp_cpu_t q;
  slp_cpu_t d;

  always_comb begin
    d = q;
    d.pcr_wr = 1'b0;
    d.sleep_exec = 1'b0;
    d.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        HREG_PCR: d.rdata = lnk.pcr_rdata;
        HREG_CMD: d.rdata = {7'h00, q.st != C_IDLE};
        HREG_STAT: d.rdata = {5'h00, q.woke_rst, q.woke_irq, lnk.halted};
        HREG_PC: d.rdata = q.pc;
        default: d.rdata = 8'h00;
      endcase
    end
    // Write-one-to-clear first, so a same-cycle wake event wins below
    if (i_wr && i_addr == HREG_STAT) begin
      if (i_wdata[STAT_IRQ_BIT]) begin
        d.woke_irq = 1'b0;
      end
      if (i_wdata[STAT_RST_BIT]) begin
        d.woke_rst = 1'b0;
      end
    end
    // Register writes other than status clears are dropped while a sleep sequence is running
    if (i_wr && q.st == C_IDLE) begin
      case (i_addr)
        HREG_PCR: begin
          d.pcr_wr = 1'b1;
          d.pcr_wdata = i_wdata;
        end
        HREG_CMD: begin
          if (i_wdata[CMD_GO_BIT]) begin
            d.st = C_SET_SE;
          end
        end
        HREG_PC: d.pc = i_wdata;
        default: d.pc = q.pc;
      endcase
    end
    case (q.st)
      C_IDLE: d.cnt = 2'h0;
      C_SET_SE: begin
        d.pcr_wr = 1'b1;
        d.pcr_wdata = lnk.pcr_rdata | 8'h40; // RULE7
        d.st = C_SLEEP;
      end
      C_SLEEP: begin
        d.sleep_exec = 1'b1; // RULE1
        d.cnt = 2'h1;
        d.st = C_CHECK;
      end
      C_CHECK: begin
        // Halt answers a cycle after the strobe is registered, so look one cycle later
        if (q.cnt != 2'h0) begin
          d.cnt = q.cnt - 2'h1;
        end else begin
          // No halt means the controller refused the mode code
          d.st = lnk.halted ? C_WAIT : C_CLR_SE; // RULE22
        end
      end
      C_WAIT: begin
        if (lnk.wake_rst) begin
          d.pc = 8'h00; // RULE5
          d.woke_rst = 1'b1;
          d.st = C_IDLE;
        end else if (lnk.wake_irq) begin
          d.isr = 1'b1; // RULE3
          d.woke_irq = 1'b1;
          d.cnt = ISR_CYC - 2'h1;
          d.st = C_ISR;
        end
      end
      C_ISR: begin
        if (q.cnt == 2'h0) begin
          d.isr = 1'b0;
          d.pc = q.pc + 8'h01; // RULE3
          d.st = C_CLR_SE;
        end else begin
          d.cnt = q.cnt - 2'h1;
        end
      end
      C_CLR_SE: begin
        d.pcr_wr = 1'b1;
        d.pcr_wdata = lnk.pcr_rdata & 8'hBF; // RULE7
        d.st = C_IDLE;
      end
      default: d = CPU_RST;
    endcase
    if (lnk.wake_rst && q.st != C_WAIT) begin
      d.woke_rst = 1'b1;
    end
    d.busy = d.st != C_IDLE;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= CPU_RST;
    end else begin
      q <= d;
    end
  end

  assign lnk.pcr_wr = q.pcr_wr;
  assign lnk.pcr_wdata = q.pcr_wdata;
  assign lnk.sleep_exec = q.sleep_exec;
  assign o_rdata = q.rdata;
  assign o_busy = q.busy;
  assign o_isr_run = q.isr;
  assign o_pc = q.pc;

endmodule // slp_cpu

// file: slp_chk.sv
// Link checker of the sleep controller pair
`timescale 1ns/1ps
module slp_chk
  import slp_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Link signals
  input wire logic pcr_wr,
  input wire logic [7:0] pcr_wdata,
  input wire logic sleep_exec,
  input wire logic [7:0] pcr_rdata,
  input wire logic halted,
  input wire logic wake_irq,
  input wire logic wake_rst
);
  logic [2:0] mode;
  assign mode = {pcr_rdata[PCR_MODE2_BIT], pcr_rdata[PCR_MODE1_BIT], pcr_rdata[PCR_MODE0_BIT]};
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  a_sleep_needs_se: assert property (sleep_exec && !pcr_rdata[PCR_SE_BIT] |=> !halted)
    else $error("sleep taken without enable bit");
  a_sleep_enters: assert property (
    sleep_exec && pcr_rdata[PCR_SE_BIT] && !mode[2] && !halted |=> halted)
    else $error("legal sleep not entered");
  a_reserved_no_sleep: assert property (sleep_exec && mode[2:1] == 2'h2 |=> !halted)
    else $error("reserved code entered sleep");
  a_irq_after_halt: assert property (
    $rose(wake_irq) |-> $past(halted, 1) && $past(halted, 2) && $past(halted, 3)
      && $past(halted, 4))
    else $error("interrupt wake without four halt cycles");
  a_irq_one_cycle: assert property (wake_irq |=> !wake_irq)
    else $error("wake pulse longer than one cycle");
  a_wake_exclusive: assert property (!(wake_irq && wake_rst))
    else $error("both wake pulses at once");
  a_halt_end_pulse: assert property (
    $fell(halted) |-> $past(wake_rst) or ##[0:1] (wake_irq || wake_rst))
    else $error("halt ended without wake pulse");
  a_rst_clears_pcr: assert property (wake_rst |-> ##[0:1] (pcr_rdata == PCR_RESET))
    else $error("reset wake left register set");
  a_pcr_write: assert property (pcr_wr && !halted |=> pcr_rdata == $past(pcr_wdata))
    else $error("register write not taken");
endmodule // slp_chk

// file: sleep_mode_controller_tb_top.sv
// Testbench of the sleep controller pair joined over their link
`timescale 1ns/1ps
module sleep_mode_controller_tb_top import slp_pkg::*;;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] src = 8'h00;
  logic rst_req = 1'b0;
  logic t2 = 1'b1;
  logic xtal = 1'b1;
  logic adc = 1'b1;
  logic [15:0] su = 16'h0003;
  logic [2:0] addr = 3'h0;
  logic [7:0] wd = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] rdata, pc, pc_exp;
  logic busy, adc_st, t2_undef, asleep, isr_run;
  logic [6:0] clks;
  logic [3:0] sense;
  logic [2:0] smode;
  int fails = 0;
  int checks = 0;

  always #12.5 clk = ~clk;

  slp_if slp_if_inst ();
  slp_ctrl slp_ctrl_inst (.i_core_clk(clk), .i_arst_n(arst_n), .lnk(slp_if_inst),
    .i_wake_src(src), .i_reset_req(rst_req), .i_t2_async(t2), .i_xtal_sel(xtal),
    .i_adc_en(adc), .i_startup_ck(su), .o_core_clk_en(clks[6]), .o_flash_clk_en(clks[5]),
    .o_io_clk_en(clks[4]), .o_adc_clk_en(clks[3]), .o_asy_clk_en(clks[2]),
    .o_osc_en(clks[1]), .o_tosc_en(clks[0]), .o_adc_start(adc_st), .o_irq_sense(sense),
    .o_t2_undef(t2_undef), .o_asleep(asleep), .o_sleep_mode(smode));
  slp_cpu slp_cpu_inst (.i_core_clk(clk), .i_arst_n(arst_n), .lnk(slp_if_inst),
    .i_addr(addr), .i_wdata(wd), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
    .o_busy(busy), .o_isr_run(isr_run), .o_pc(pc));
  slp_chk slp_chk_inst (.i_core_clk(clk), .i_arst_n(arst_n), .pcr_wr(slp_if_inst.pcr_wr),
    .pcr_wdata(slp_if_inst.pcr_wdata), .sleep_exec(slp_if_inst.sleep_exec),
    .pcr_rdata(slp_if_inst.pcr_rdata), .halted(slp_if_inst.halted),
    .wake_irq(slp_if_inst.wake_irq), .wake_rst(slp_if_inst.wake_rst));

  // ********************************
  // Shared tasks
  // ********************************
  task stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  // Two spare cycles let the write reach the controller before a read
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask

  function automatic logic cond(input int w);
    case (w)
      0: return asleep === 1'b1;
      1: return clks[6] === 1'b1;
      2: return busy === 1'b0;
      default: return slp_if_inst.wake_rst === 1'b1;
    endcase
  endfunction

  task wait_c(input int w, output int n);
    n = 0;
    #1;
    while (!cond(w)) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 300) begin
        fails++;
        stop_test();
      end
    end
  endtask

  // ********************************
  // Scenarios
  // ********************************
  task sleep_run(input logic [2:0] m, input logic [7:0] bad, input logic [7:0] good,
                 input logic [6:0] ck, input int d);
    int n;
    int h;
    logic [7:0] v;
    wr(HREG_PCR, {m[2], 1'b0, m[1:0], 4'hA});
    wr(HREG_CMD, 8'h01);
    wait_c(0, n);
    chk(adc_st, m < 3'h2);
    chk(clks, ck);
    chk(smode, m);
    chk(sense, 4'hA);
    @(posedge clk);
    src <= bad;
    repeat (10) @(posedge clk);
    #1 chk(asleep, 1'b1);
    @(posedge clk);
    src <= good;
    wait_c(1, n);
    chk(n >= d && n <= d + 3, 1'b1);
    h = 0;
    while (asleep === 1'b1 && h < 20) begin
      h++;
      @(posedge clk);
      #1;
    end
    chk(h, 4);
    @(posedge clk);
    src <= 8'h00;
    h = 0;
    for (int i = 0; i < 8; i++) begin
      #1 h += isr_run;
      @(posedge clk);
    end
    chk(h, ISR_CYC);
    wait_c(2, n);
    pc_exp++;
    chk(pc, pc_exp);
    rd(HREG_PC, v);
    chk(v, pc_exp);
    rd(HREG_PCR, v);
    chk(v, {m[2], 1'b0, m[1:0], 4'hA});
    rd(HREG_STAT, v);
    chk(v, 8'h02);
    wr(HREG_STAT, 8'h06);
  endtask

  task refuse(input logic [2:0] m, input logic xt);
    logic seen;
    @(posedge clk);
    xtal <= xt;
    seen = 1'b0;
    wr(HREG_PCR, {m[2], 1'b0, m[1:0], 4'h0});
    wr(HREG_CMD, 8'h01);
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      #1 seen |= asleep;
    end
    chk(seen, 1'b0);
    chk(busy, 1'b0);
    @(posedge clk);
    xtal <= 1'b1;
  endtask

  task rst_wake;
    int n;
    logic [7:0] v;
    wr(HREG_PCR, 8'h20);
    wr(HREG_CMD, 8'h01);
    wait_c(0, n);
    @(posedge clk);
    rst_req <= 1'b1;
    wait_c(3, n);
    @(posedge clk);
    rst_req <= 1'b0;
    wait_c(2, n);
    rd(HREG_PCR, v);
    chk(v, 8'h00);
    rd(HREG_PC, v);
    chk(v, 8'h00);
    rd(HREG_STAT, v);
    chk(v, 8'h04);
  endtask

  initial begin
    logic [7:0] v;
    pc_exp = 8'h00;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    rd(HREG_PCR, v);
    chk(v, PCR_RESET);
    chk(clks, CLK_ALL_ON);
    rd(3'h4, v);
    chk(v, 8'h00);
    wr(HREG_PCR, 8'hB5);
    rd(HREG_PCR, v);
    chk(v, 8'hB5);
    chk(sense, 4'h5);
    sleep_run(3'h0, 8'h00, 8'h80, 7'h1F, 0);
    sleep_run(3'h1, 8'h80, 8'h01, 7'h0F, 0);
    sleep_run(3'h2, 8'h01, 8'h08, 7'h00, 3);
    sleep_run(3'h3, 8'h20, 8'h10, 7'h05, 3);
    sleep_run(3'h6, 8'h10, 8'h02, 7'h02, 6);
    sleep_run(3'h7, 8'h20, 8'h10, 7'h07, 6);
    refuse(3'h4, 1'b1);
    refuse(3'h5, 1'b1);
    refuse(3'h6, 1'b0);
    refuse(3'h7, 1'b0);
    @(posedge clk);
    t2 <= 1'b0;
    sleep_run(3'h3, 8'h10, 8'h08, 7'h00, 3);
    chk(t2_undef, 1'b1);
    @(posedge clk);
    t2 <= 1'b1;
    rst_wake();
    stop_test();
  end
endmodule // sleep_mode_controller_tb_top
